// file: core/timer8_compare_pulse_pwm.sv
// 8-bit timer output compare, single-pulse and pwm core
//
// How it works
// - match sets flag, drives level if enabled
// - compare pin latch low during reset
// - compare flag interrupts when enabled and unmasked
// - flag clears after status read then access
// - pin disabled: no drive, flag still sets
// - force copies level, no flag or irq
// - force ignored in single-pulse and pwm
// - trigger loads fch, level two, fffdh capture
// - single-pulse match one ends pulse level one
// - single-pulse: no flag one, pin two silent
// - both mode bits set means pwm only
// - single-pulse: input one no capture, two captures
// - pwm compare values double-buffered per period
// - pwm match two reloads counter fch
// - pwm pin takes level one then two
// - pwm never sets compare flags
// - pwm match two sets capture flag one
// - pwm: input one disconnected, two captures
// - halt freezes counter, wait has no effect
// - halt edge arms capture until interrupt wake
// - clock select picks divide four/two/eight/osc
// - counter loads fch on reset or write
`timescale 1ns/100ps
`default_nettype none
module timer8_compare_pulse_pwm #(
    parameter int unsigned OSC_DIV = tim8_pkg::OSC_DIV_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // configuration bits
    input wire logic [1:0] compare_pin_enable,
    input wire logic [1:0] compare_level,
    input wire logic [1:0] force_compare,
    input wire logic compare_irq_enable,
    input wire logic capture_irq_enable,
    input wire logic cpu_irq_mask,
    input wire logic single_pulse_select,
    input wire logic pwm_select,
    input wire tim8_pkg::csel_t clock_select,
    input wire logic capture_edge_select_one,
    input wire logic capture_edge_select_two,
    // software access strobes
    input wire logic status_read,
    input wire logic [1:0] compare_access,
    input wire logic [1:0] compare_write,
    input wire tim8_pkg::cnt_t compare_wdata,
    input wire logic [1:0] capture_access,
    input wire logic counter_write,
    // power modes
    input wire logic halt,
    input wire logic wake_irq,
    // pins and secondary oscillator
    input wire logic capture_input_one,
    input wire logic capture_input_two,
    input wire logic osc2_in,
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_output_oe,
    // status
    output logic [1:0] compare_flag,
    output logic capture_flag_one,
    output logic capture_flag_two,
    output tim8_pkg::cap_t capture_value_one,
    output tim8_pkg::cap_t capture_value_two,
    output tim8_pkg::cnt_t counter_value,
    output logic timer_irq
);
    import tim8_pkg::*;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    tick_if tk ();
    assign tk.sel = clock_select;
    assign tk.osc2 = osc2_in;
    assign tk.halt = halt;

    tim8_prescaler #(.OSC_DIV(OSC_DIV)) u_presc (
        .mclk(mclk),
        .arst_n(arst_n),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cnt_t cnt_reg;
    cnt_t cnt_next;
    cnt_t ocr_reg [2];
    cnt_t act_reg [2];
    logic [1:0] cflag_reg;
    logic [1:0] carm_reg;
    logic [1:0] iflag_reg;
    logic [1:0] iarm_reg;
    logic [1:0] harm_reg;
    cap_t icr_reg [2];
    logic [1:0] pin_reg;
    logic [1:0] pin_next;
    logic [1:0] oe_reg;
    logic cap1_prev_reg;
    logic cap2_prev_reg;
    logic irq_reg;

    // ------------------------------------------------------------
    // mode and event decode
    // ------------------------------------------------------------
    // pwm wins over single-pulse
    wire pwm_on = pwm_select;
    wire opm_on = single_pulse_select & ~pwm_select;
    wire norm_on = ~pwm_on & ~opm_on;
    wire div2 = (clock_select == CS_DIV2);
    wire tick = tk.tick & ~halt;
    wire cnt_t cnt_inc = cnt_reg + 8'h01;
    wire [1:0] match;
    wire [1:0] cset;
    wire [1:0] iset;
    wire [1:0] iload;
    wire cap_t ival [2];
    wire c1_edge = capture_edge_select_one ?
                   (capture_input_one & ~cap1_prev_reg) :
                   (~capture_input_one & cap1_prev_reg);
    wire c2_edge = capture_edge_select_two ?
                   (capture_input_two & ~cap2_prev_reg) :
                   (~capture_input_two & cap2_prev_reg);
    // single-pulse trigger replaces capture one
    wire trig1 = opm_on & c1_edge & ~halt;
    wire cap1_now = norm_on & c1_edge & ~halt;
    wire cap2_now = c2_edge & ~halt;
    wire [1:0] hedge = {c2_edge, c1_edge & norm_on};
    wire period_end = pwm_on & match[1];

    // ------------------------------------------------------------
    // per-channel compare and capture state
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < 2; gi++) begin : g_ch
        // div2 hits at the value, slower clocks one count later
        wire cnt_t tgt = div2 ? act_reg[gi] : act_reg[gi] + 8'h01;
        // evaluated only on the timer tick
        assign match[gi] = tick & (cnt_inc == tgt);
        // no compare flags in pwm, none on channel one in pulse mode
        assign cset[gi] = match[gi] & ~pwm_on &
                          ~(opm_on & (gi == 0));

        // compare value and active copy
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                ocr_reg[gi] <= OCR_RST;
                act_reg[gi] <= OCR_RST;
            end else begin
                if (compare_write[gi]) begin
                    ocr_reg[gi] <= compare_wdata;
                end
                // pwm copies only at period end
                if (!pwm_on || period_end) begin
                    act_reg[gi] <= ocr_reg[gi];
                end
            end
        end

        // compare flag: set wins over the two-step clear
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                cflag_reg[gi] <= 1'b0;
                carm_reg[gi] <= 1'b0;
            end else begin
                cflag_reg[gi] <= cset[gi] |
                    (cflag_reg[gi] & ~(carm_reg[gi] & compare_access[gi]));
                carm_reg[gi] <= (status_read & cflag_reg[gi]) |
                    (carm_reg[gi] & ~compare_access[gi]);
            end
        end

        // capture flag, value and halt arming
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                iflag_reg[gi] <= 1'b0;
                iarm_reg[gi] <= 1'b0;
                harm_reg[gi] <= 1'b0;
                icr_reg[gi] <= '0;
            end else begin
                iflag_reg[gi] <= iset[gi] |
                    (iflag_reg[gi] & ~(iarm_reg[gi] & capture_access[gi]));
                iarm_reg[gi] <= (status_read & iflag_reg[gi]) |
                    (iarm_reg[gi] & ~capture_access[gi]);
                // edge seen in halt waits for the wake
                harm_reg[gi] <= (halt & hedge[gi]) |
                    (harm_reg[gi] & ~wake_irq);
                if (iload[gi]) begin
                    icr_reg[gi] <= ival[gi];
                end
            end
        end
    end

    // capture sources per channel
    assign iset[0] = iload[0] | period_end;
    assign iload[0] = cap1_now | trig1 | (harm_reg[0] & wake_irq);
    assign iset[1] = iload[1];
    assign iload[1] = cap2_now | (harm_reg[1] & wake_irq);
    assign ival[0] = trig1 ? CAP1_OPM : {8'h00, cnt_reg};
    assign ival[1] = {8'h00, cnt_reg};

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // reload on write, pulse trigger or pwm period end
    assign cnt_next = (counter_write | trig1 | period_end) ? CNT_RST :
                      tick ? cnt_inc : cnt_reg;

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    // pin one: pulse, pwm or plain compare with force
    assign pin_next[0] =
        opm_on ? (trig1 ? compare_level[1] :
                  match[0] ? compare_level[0] : pin_reg[0]) :
        pwm_on ? (match[1] ? compare_level[1] :
                  match[0] ? compare_level[0] : pin_reg[0]) :
        (compare_pin_enable[0] & (match[0] | force_compare[0])) ?
            compare_level[0] : pin_reg[0];
    // pin two drives only in plain compare mode
    assign pin_next[1] = (norm_on & compare_pin_enable[1] &
                          (match[1] | force_compare[1])) ?
                         compare_level[1] : pin_reg[1];

    // ------------------------------------------------------------
    // registers and outputs
    // ------------------------------------------------------------
    wire irq_next = ~cpu_irq_mask &
                    ((compare_irq_enable & |cflag_reg) |
                     (capture_irq_enable & |iflag_reg));

    // counter, pins, edges and interrupt
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= CNT_RST;
            pin_reg <= 2'h0;
            oe_reg <= 2'h0;
            cap1_prev_reg <= 1'b0;
            cap2_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pin_reg <= pin_next;
            oe_reg <= compare_pin_enable;
            cap1_prev_reg <= capture_input_one;
            cap2_prev_reg <= capture_input_two;
            irq_reg <= irq_next;
        end
    end

    assign compare_output_pin = pin_reg;
    assign compare_output_oe = oe_reg;
    assign compare_flag = cflag_reg;
    assign capture_flag_one = iflag_reg[0];
    assign capture_flag_two = iflag_reg[1];
    assign capture_value_one = icr_reg[0];
    assign capture_value_two = icr_reg[1];
    assign counter_value = cnt_reg;
    assign timer_irq = irq_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    property p_flag_on_match;
        norm_on && match[0] |=> compare_flag[0];
    endproperty
    a_flag_on_match: assert property (p_flag_on_match)
        else $error("compare flag one not set on match");

    property p_irq_from_flag;
        compare_flag[1] && compare_irq_enable && !cpu_irq_mask |=> timer_irq;
    endproperty
    a_irq_from_flag: assert property (p_irq_from_flag)
        else $error("compare flag did not raise interrupt");

    property p_no_clear_unarmed;
        compare_flag[0] && !carm_reg[0] |=> compare_flag[0];
    endproperty
    a_no_clear_unarmed: assert property (p_no_clear_unarmed)
        else $error("compare flag cleared without status read");

    property p_pin2_idle;
        !compare_pin_enable[1] |=> $stable(compare_output_pin[1]);
    endproperty
    a_pin2_idle: assert property (p_pin2_idle)
        else $error("disabled pin two changed");

    property p_pin2_modes;
        !norm_on |=> $stable(compare_output_pin[1]);
    endproperty
    a_pin2_modes: assert property (p_pin2_modes)
        else $error("pin two moved in pulse or pwm mode");

    property p_trigger;
        trig1 |=> counter_value == CNT_RST && capture_flag_one &&
                  capture_value_one == CAP1_OPM &&
                  compare_output_pin[0] == $past(compare_level[1]);
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("single-pulse trigger effects missing");

    property p_pwm_reload;
        period_end && !counter_write |=> counter_value == CNT_RST ##1
            counter_value == CNT_RST || counter_value == 8'hfd;
    endproperty
    a_pwm_reload: assert property (p_pwm_reload)
        else $error("pwm period did not reload counter");

    property p_pwm_no_flags;
        pwm_on && compare_flag == 2'h0 |=> compare_flag == 2'h0;
    endproperty
    a_pwm_no_flags: assert property (p_pwm_no_flags)
        else $error("compare flag set in pwm mode");

    property p_halt_freeze;
        halt && !counter_write |=> $stable(counter_value);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze)
        else $error("counter moved during halt");

    c_opm_pulse: cover property (trig1 ##[1:1000] opm_on && match[0]);
    c_pwm_period: cover property (pwm_on && match[0] ##[1:1000] period_end);
    c_irq: cover property ($rose(timer_irq));
    c_halt_wake: cover property (harm_reg[1] && wake_irq);
endmodule // timer8_compare_pulse_pwm
`default_nettype wire

// file: core/tim8_pkg.sv
// constants and types shared by the 8-bit timer compare block
package tim8_pkg;
    typedef logic [7:0] cnt_t;
    typedef logic [15:0] cap_t;
    typedef logic [1:0] csel_t;
    typedef logic [12:0] div_t;
    // counter value after reset, write, trigger or period end
    localparam cnt_t CNT_RST = 8'hfc;
    // capture value one loaded by a single-pulse trigger
    localparam cap_t CAP1_OPM = 16'hfffd;
    // compare value after reset
    localparam cnt_t OCR_RST = 8'h00;
    // clock select codes
    localparam csel_t CS_DIV4 = 2'h0;
    localparam csel_t CS_DIV2 = 2'h1;
    localparam csel_t CS_DIV8 = 2'h2;
    localparam csel_t CS_OSC = 2'h3;
    // prescaler terminal counts (divide factor minus one)
    localparam div_t DIV2_TERM = 13'h0001;
    localparam div_t DIV4_TERM = 13'h0003;
    localparam div_t DIV8_TERM = 13'h0007;
    // secondary oscillator rising edges per timer tick
    localparam int unsigned OSC_DIV_DEF = 8000;
endpackage

// file: core/tick_if.sv
// prescaler control and tick between the timer core and its prescaler
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
    import tim8_pkg::*;
    csel_t sel;
    logic osc2;
    logic halt;
    logic tick;
    modport src (input sel, input osc2, input halt, output tick);
    modport dst (output sel, output osc2, output halt, input tick);
endinterface // tick_if
`default_nettype wire

// file: core/tim8_prescaler.sv
// timer clock prescaler: one-cycle tick per timer count
`timescale 1ns/100ps
`default_nettype none
module tim8_prescaler #(
    parameter int unsigned OSC_DIV = tim8_pkg::OSC_DIV_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // control in, tick out
    tick_if.src tk
);
    import tim8_pkg::*;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    div_t div_reg;
    div_t div_next;
    logic osc_prev_reg;
    logic tick_reg;
    wire osc_rise = tk.osc2 & ~osc_prev_reg;
    // select terminal count from clock select
    wire div_t term = (tk.sel == CS_DIV2) ? DIV2_TERM :
                      (tk.sel == CS_DIV4) ? DIV4_TERM :
                      (tk.sel == CS_DIV8) ? DIV8_TERM :
                      div_t'(OSC_DIV - 1);
    // halt freezes the count
    wire step = ~tk.halt & ((tk.sel == CS_OSC) ? osc_rise : 1'b1);
    wire wrap = step & (div_reg >= term);
    assign div_next = wrap ? '0 : step ? div_reg + 13'h0001 : div_reg;
    assign tk.tick = tick_reg;

    // divider registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
            osc_prev_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            osc_prev_reg <= tk.osc2;
            tick_reg <= wrap;
        end
    end
endmodule // tim8_prescaler
`default_nettype wire

// file: sim/cap_pin_source.sv
// capture pin and secondary oscillator source facing the timer pins
`timescale 1ns/100ps
`default_nettype none
module cap_pin_source (
    // clock
    input wire logic mclk,
    // pins toward the timer
    output logic cap_one,
    output logic cap_two,
    output logic osc2
);
    // oscillator runs free, its edges kept clear of mclk edges
    initial begin
        cap_one = 1'b0;
        cap_two = 1'b0;
        osc2 = 1'b0;
        #7;
        forever #60 osc2 = ~osc2;
    end

    // two level changes on a capture pin, returns just after the second
    task automatic make_edge(input int ch, input logic rising, input int dly);
        repeat (dly) @(posedge mclk);
        #1;
        if (ch == 1) begin
            cap_one = ~rising;
        end else begin
            cap_two = ~rising;
        end
        repeat (dly + 2) @(posedge mclk);
        #1;
        if (ch == 1) begin
            cap_one = rising;
        end else begin
            cap_two = rising;
        end
    endtask
endmodule // cap_pin_source
`default_nettype wire

// file: sim/timer8_compare_pulse_pwm_tb.sv
// self-checking bench for the 8-bit timer compare, pulse and pwm core
`timescale 1ns/100ps
`default_nettype none
module timer8_compare_pulse_pwm_tb;
    import tim8_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int unsigned SIM_OSC_DIV = 4;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] compare_pin_enable = 2'h0, compare_level = 2'h0;
    logic [1:0] force_compare = 2'h0, compare_access = 2'h0;
    logic [1:0] compare_write = 2'h0, capture_access = 2'h0;
    logic compare_irq_enable = 1'b0, capture_irq_enable = 1'b0;
    logic cpu_irq_mask = 1'b1, single_pulse_select = 1'b0;
    logic pwm_select = 1'b0, status_read = 1'b0, counter_write = 1'b0;
    logic capture_edge_select_one = 1'b1, capture_edge_select_two = 1'b1;
    logic halt = 1'b0, wake_irq = 1'b0;
    csel_t clock_select = CS_DIV2;
    cnt_t compare_wdata = 8'h00;
    wire logic capture_input_one, capture_input_two, osc2_in;
    logic [1:0] compare_output_pin, compare_output_oe, compare_flag;
    logic capture_flag_one, capture_flag_two, timer_irq;
    cap_t capture_value_one, capture_value_two;
    cnt_t counter_value, cv, cv2, act, nxt, c0;
    int error_cnt = 0, n_compared = 0, cycle_cnt = 0;
    int k, iv, i, bad;
    logic [1:0] pp;
    logic pe;
    csel_t codes[3] = '{CS_DIV2, CS_DIV4, CS_DIV8};
    int divs[3] = '{2, 4, 8};

    cap_pin_source src (.mclk, .cap_one(capture_input_one),
        .cap_two(capture_input_two), .osc2(osc2_in));
    timer8_compare_pulse_pwm #(.OSC_DIV(SIM_OSC_DIV)) dut (.mclk, .arst_n,
        .compare_pin_enable, .compare_level, .force_compare,
        .compare_irq_enable, .capture_irq_enable, .cpu_irq_mask,
        .single_pulse_select, .pwm_select, .clock_select,
        .capture_edge_select_one, .capture_edge_select_two, .status_read,
        .compare_access, .compare_write, .compare_wdata, .capture_access,
        .counter_write, .halt, .wake_irq, .capture_input_one,
        .capture_input_two, .osc2_in, .compare_output_pin,
        .compare_output_oe, .compare_flag, .capture_flag_one,
        .capture_flag_two, .capture_value_one, .capture_value_two,
        .counter_value, .timer_irq);

    // ----------------------------------------
    // clock, timeout and helper tasks
    // ----------------------------------------
    always #10 mclk = ~mclk;

    // hang guard far above the expected run length
    always @(posedge mclk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic write_cmp(input int ch, input cnt_t v);
        compare_write[ch] = 1'b1;
        compare_wdata = v;
        step(1);
        compare_write = 2'h0;
        step(1);
    endtask

    task automatic restart();
        counter_write = 1'b1;
        step(1);
        counter_write = 1'b0;
    endtask

    // status read, then access of the value register of that flag
    task automatic clear_flag(input logic cap, input int ch);
        status_read = 1'b1;
        step(1);
        status_read = 1'b0;
        if (cap) begin
            capture_access[ch] = 1'b1;
        end else begin
            compare_access[ch] = 1'b1;
        end
        step(1);
        capture_access = 2'h0;
        compare_access = 2'h0;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        k = $urandom(25);
        step(2);
        arst_n = 1'b1;
        check("counter_rst", counter_value, CNT_RST);
        check("pin_rst", compare_output_pin, 2'h0);
        check("flag_rst", {compare_flag, timer_irq}, 3'h0);
        // plain compare per divider setting: divide two, four and eight
        for (int j = 0; j < 3; j++) begin
            i = j % 2;
            clock_select = codes[j];
            pe = 1'($urandom % 2);
            compare_pin_enable = {pe, pe};
            compare_level = 2'($urandom);
            cv = 8'h03 + 8'($urandom % 12);
            pp = compare_output_pin;
            write_cmp(i, cv);
            restart();
            for (k = 0; k < 20 && counter_value == CNT_RST; k++) step(1);
            c0 = counter_value;
            for (iv = 0; iv < 20 && counter_value == c0; iv++) step(1);
            check("tick_gap", 16'(iv), 16'(divs[j]));
            check("tick_inc", counter_value, 8'(c0 + 1));
            clear_flag(1'b0, i); // drop a flag left from the last round
            for (k = 0; k < 400 && compare_flag[i] !== 1'b1; k++) step(1);
            check("match_cnt", counter_value, 8'(cv + (j > 0)));
            check("match_pin", compare_output_pin[i],
                  pe ? compare_level[i] : pp[i]);
            compare_irq_enable = 1'b1;
            step(2);
            check("irq_masked", timer_irq, 1'b0);
            cpu_irq_mask = 1'b0;
            step(2);
            check("irq_on", timer_irq, 1'b1);
            compare_access[i] = 1'b1;
            step(1);
            compare_access = 2'h0;
            check("flag_kept", compare_flag[i], 1'b1);
            clear_flag(1'b0, i);
            check("flag_clr", compare_flag[i], 1'b0);
            clear_flag(1'b0, 1 - i);
            cpu_irq_mask = 1'b1;
            compare_irq_enable = 1'b0;
        end
        // secondary oscillator clock
        clock_select = CS_OSC;
        restart();
        for (k = 0; k < 60 && counter_value == CNT_RST; k++) step(1);
        c0 = counter_value;
        for (iv = 0; iv < 60 && counter_value == c0; iv++) step(1);
        check("osc_gap", 16'(iv >= 22 && iv <= 29), 16'h1);
        // forced output, then ignored in pwm
        clear_flag(1'b0, 0);
        clear_flag(1'b0, 1);
        clock_select = CS_DIV8;
        restart();
        compare_pin_enable = 2'h3;
        compare_irq_enable = 1'b1;
        cpu_irq_mask = 1'b0;
        compare_level = 2'h2;
        force_compare = 2'h3;
        step(2);
        check("force_pin", compare_output_pin, 2'h2);
        check("force_oe", compare_output_oe, 2'h3);
        compare_level = 2'h1;
        step(2);
        check("force_pin2", compare_output_pin, 2'h1);
        check("force_flag", {compare_flag, timer_irq}, 3'h0);
        pwm_select = 1'b1;
        compare_level = 2'h2;
        step(2);
        check("force_pwm", compare_output_pin, 2'h1);
        pwm_select = 1'b0;
        force_compare = 2'h0;
        compare_irq_enable = 1'b0;
        // halt freezes counter and arms capture two
        clock_select = CS_DIV2;
        restart();
        step(5);
        halt = 1'b1;
        step(2);
        c0 = counter_value;
        src.make_edge(2, 1'b1, 1);
        step(8);
        check("halt_cnt", counter_value, c0);
        check("halt_flag", capture_flag_two, 1'b0);
        halt = 1'b0;
        wake_irq = 1'b1;
        step(1);
        wake_irq = 1'b0;
        for (k = 0; k < 6 && capture_flag_two !== 1'b1; k++) step(1);
        check("wake_flag", capture_flag_two, 1'b1);
        check("wake_cap", capture_value_two, {8'h00, c0});
        clear_flag(1'b1, 1);
        check("cap2_clr", capture_flag_two, 1'b0);
        // single pulse on both trigger polarities, prompt and slow
        single_pulse_select = 1'b1;
        compare_pin_enable = 2'h1;
        compare_level = 2'h2;
        cv = 8'h10 + 8'($urandom % 16);
        write_cmp(0, cv);
        for (int s = 0; s < 2; s++) begin
            capture_edge_select_one = s[0];
            src.make_edge(1, s[0], 1 + s * 3);
            for (k = 0; k < 12 && capture_flag_one !== 1'b1; k++) step(1);
            check("opm_cnt", counter_value, CNT_RST);
            check("opm_pin", compare_output_pin[0], 1'b1);
            check("opm_cap", capture_value_one, CAP1_OPM);
            for (k = 0; k < 200 && compare_output_pin[0] !== 1'b0; k++)
                step(1);
            check("opm_end", counter_value, cv);
            check("opm_flag1", compare_flag[0], 1'b0);
            clear_flag(1'b1, 0);
        end
        // pwm with both mode bits set, duty moved mid-period
        single_pulse_select = 1'b0;
        act = 8'h08;
        cv2 = 8'h20; // period value chosen by software
        write_cmp(0, act);
        write_cmp(1, cv2);
        single_pulse_select = 1'b1;
        pwm_select = 1'b1;
        compare_level = 2'h1;
        compare_irq_enable = 1'b1;
        capture_irq_enable = 1'b1;
        restart();
        clear_flag(1'b0, 1);
        nxt = act;
        bad = 0;
        iv = 0;
        pp = compare_output_pin;
        c0 = counter_value;
        for (k = 0; k < 600; k++) begin
            step(1);
            if (compare_write != 2'h0)
                compare_write = 2'h0;
            if (counter_value == CNT_RST && c0 != CNT_RST)
                act = nxt;
            if (compare_output_pin[0] && !pp[0]) begin
                iv++;
                check("pwm_rise", counter_value, act);
                if (nxt == act && act < 8'h14) begin
                    nxt = act + 8'h04;
                    compare_wdata = nxt;
                    compare_write = 2'h1;
                end
            end
            if (counter_value > cv2 && counter_value < CNT_RST)
                bad++;
            if (compare_flag != 2'h0)
                bad++;
            pp = compare_output_pin;
            c0 = counter_value;
        end
        check("pwm_bad", 16'(bad), 16'h0);
        check("pwm_rises", 16'(iv >= 4), 16'h1);
        check("pwm_cap1", capture_flag_one, 1'b1);
        check("pwm_irq", timer_irq, 1'b1);
        end_of_test();
    end
endmodule // timer8_compare_pulse_pwm_tb
`default_nettype wire
